/* File: core/ssam_regs.svh */
// Constants for the serial slave address map: function codes, offsets, space sizes.
// Assumes inclusion by bare name from the design files.
`ifndef SSAM_REGS_SVH
`define SSAM_REGS_SVH
`define SSAM_FC_RD_COILS 8'h01
`define SSAM_FC_RD_INPUTS 8'h02
`define SSAM_FC_RD_HOLD 8'h03
`define SSAM_FC_RD_INREG 8'h04
`define SSAM_FC_WR_COIL 8'h05
`define SSAM_FC_WR_REG 8'h06
`define SSAM_FC_WR_COILS 8'h0f
`define SSAM_FC_WR_REGS 8'h10
`define SSAM_OFS_0 16'h0000
`define SSAM_OFS_512 16'h0200
`define SSAM_OFS_3000 16'h0bb8
`define SSAM_OFS_4000 16'h0fa0
`define SSAM_OFS_5000 16'h1388
`define SSAM_OFS_6000 16'h1770
`define SSAM_OFS_9000 16'h2328
`define SSAM_OFS_10000 16'h2710
`define SSAM_N_1024 16'h0400
`define SSAM_N_256 16'h0100
`define SSAM_N_10 16'h000a
`define SSAM_N_32 16'h0020
`define SSAM_N_200 16'h00c8
`define SSAM_N_2488 16'h09b8
`define SSAM_N_2048 16'h0800
`define SSAM_N_5000 16'h1388
`define SSAM_REF_DIV 17'h02710
`define SSAM_REF_LIMIT 17'h0c350
`define SSAM_MAX_QTY 16'h07d0
`endif

/* File: core/ssam_pkg.sv */
// Types for the serial slave address map.
// Assumes the constants header is included by users that need numbers.
package ssam_pkg;
    typedef enum logic [3:0] {
        SP_NONE, SP_INPUT_BITS, SP_GLOBAL_INPUT_BITS, SP_SYSTEM_BITS, SP_KEY_BITS,
        SP_OUTPUT_BITS, SP_MEMORY_BITS, SP_TEMP_BITS, SP_GLOBAL_OUTPUT_BITS,
        SP_ANALOG_INPUTS, SP_GLOBAL_ANALOG_INPUTS, SP_SYSTEM_REGISTERS,
        SP_ANALOG_OUTPUTS, SP_GENERAL_REGISTERS, SP_GLOBAL_ANALOG_OUTPUTS
    } ssam_space_t;
    typedef enum logic [1:0] {
        EX_NONE, EX_FUNCTION, EX_ADDRESS
    } ssam_err_t;
    typedef struct packed {
        logic [7:0] slave_id;
        logic [7:0] func;
        logic [15:0] offset;
        logic [15:0] qty;
    } ssam_req_t;
    typedef struct packed {
        ssam_space_t space;
        logic [15:0] index;
        logic write;
        ssam_err_t err;
    } ssam_resp_t;
endpackage

/* File: core/ssam_ref_split.sv */
// Splits a traditional five-digit reference into function-class digit and offset.
// Assumes the reference is held stable while ref_valid is high; one cycle latency.
`timescale 1ns/1ps
`include "ssam_regs.svh"
module ssam_ref_split (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Reference in
    input wire logic ref_valid,
    input wire logic [16:0] ref_num,
    // Split out
    output logic split_valid,
    output logic [3:0] split_digit,
    output logic [15:0] split_offset,
    output logic split_bad
);
    logic next_split_valid;
    logic [3:0] next_split_digit;
    logic [15:0] next_split_offset;
    logic next_split_bad;
    logic [16:0] rest;

    // Leading digit picks the type, the rest is one-based
    always_comb begin
        rest = ref_num % `SSAM_REF_DIV;
        next_split_valid = ref_valid;
        next_split_digit = 4'(ref_num / `SSAM_REF_DIV);
        next_split_bad = (rest == 17'h00000) || (ref_num >= `SSAM_REF_LIMIT);
        next_split_offset = 16'(rest - 17'h00001);
    end

    // Register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            split_valid <= 1'b0;
            split_digit <= 4'h0;
            split_offset <= 16'h0000;
            split_bad <= 1'b0;
        end else begin
            split_valid <= next_split_valid;
            split_digit <= next_split_digit;
            split_offset <= next_split_offset;
            split_bad <= next_split_bad;
        end
    end
endmodule

/* File: core/ssam_decoder.sv */
// Serial slave address map: decodes requests to internal data spaces.
// Assumes requests come from same-clock framing logic, CRC already checked.
//
// Summary of operation
// - Reference leading digit picks type; remaining digits are a one-based index.
// - Several internal spaces live inside each public type, chosen by start offset.
// - Function 2: inputs 0, global inputs 3000, system bits 4000, keys 5000.
// - Function 1: outputs 0, memory 3000, temporary 6000, global outputs 9000.
// - Functions 5 and 15 write coils over the same ranges as function 1.
// - Function 4: analog inputs 0, global analog 3000, system registers 4000.
// - Only addressed slave answers; failures answer with an error response.
`timescale 1ns/1ps
`include "ssam_regs.svh"
module ssam_decoder (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Own slave address
    input wire logic [7:0] own_id,
    // Explicit request
    input wire logic req_valid,
    input wire ssam_pkg::ssam_req_t req,
    // Traditional reference request
    input wire logic ref_valid,
    input wire logic [7:0] ref_slave_id,
    input wire logic ref_write,
    input wire logic [16:0] ref_num,
    // Decoded answer
    output logic resp_valid,
    output ssam_pkg::ssam_resp_t resp
);
    logic split_valid;
    logic [3:0] split_digit;
    logic [15:0] split_offset;
    logic split_bad;
    logic [7:0] ref_id_q;
    logic ref_write_q;
    logic [7:0] next_ref_id_q;
    logic next_ref_write_q;
    logic next_resp_valid;
    ssam_pkg::ssam_resp_t next_resp;
    ssam_pkg::ssam_resp_t dec;

    // Range test used by every space
    function automatic logic in_range(input logic [15:0] ofs, input logic [15:0] base,
                                      input logic [15:0] size);
        in_range = (ofs >= base) && ({1'b0, ofs} < ({1'b0, base} + {1'b0, size}));
    endfunction

    // Map one function class and zero-based offset to an internal space
    function automatic ssam_pkg::ssam_resp_t map_space(input logic [7:0] fc,
                                                       input logic [15:0] ofs);
        ssam_pkg::ssam_resp_t r;
        r.space = ssam_pkg::SP_NONE;
        r.index = 16'h0000;
        r.write = (fc == `SSAM_FC_WR_COIL) || (fc == `SSAM_FC_WR_COILS) ||
                  (fc == `SSAM_FC_WR_REG) || (fc == `SSAM_FC_WR_REGS);
        r.err = ssam_pkg::EX_NONE;
        unique case (fc)
            `SSAM_FC_RD_INPUTS: begin
                if (in_range(ofs, `SSAM_OFS_0, `SSAM_N_1024)) begin
                    r.space = ssam_pkg::SP_INPUT_BITS;
                    r.index = ofs;
                end else if (in_range(ofs, `SSAM_OFS_3000, `SSAM_N_256)) begin
                    r.space = ssam_pkg::SP_GLOBAL_INPUT_BITS;
                    r.index = ofs - `SSAM_OFS_3000;
                end else if (in_range(ofs, `SSAM_OFS_4000, `SSAM_N_256)) begin
                    r.space = ssam_pkg::SP_SYSTEM_BITS;
                    r.index = ofs - `SSAM_OFS_4000;
                end else if (in_range(ofs, `SSAM_OFS_5000, `SSAM_N_10)) begin
                    r.space = ssam_pkg::SP_KEY_BITS;
                    r.index = ofs - `SSAM_OFS_5000;
                end
            end
            `SSAM_FC_RD_COILS, `SSAM_FC_WR_COIL, `SSAM_FC_WR_COILS: begin
                if (in_range(ofs, `SSAM_OFS_0, `SSAM_N_1024)) begin
                    r.space = ssam_pkg::SP_OUTPUT_BITS;
                    r.index = ofs;
                end else if (in_range(ofs, `SSAM_OFS_3000, `SSAM_N_1024)) begin
                    r.space = ssam_pkg::SP_MEMORY_BITS;
                    r.index = ofs - `SSAM_OFS_3000;
                end else if (in_range(ofs, `SSAM_OFS_6000, `SSAM_N_1024)) begin
                    r.space = ssam_pkg::SP_TEMP_BITS;
                    r.index = ofs - `SSAM_OFS_6000;
                end else if (in_range(ofs, `SSAM_OFS_9000, `SSAM_N_256)) begin
                    r.space = ssam_pkg::SP_GLOBAL_OUTPUT_BITS;
                    r.index = ofs - `SSAM_OFS_9000;
                end
            end
            `SSAM_FC_RD_INREG: begin
                if (in_range(ofs, `SSAM_OFS_0, `SSAM_N_256)) begin
                    r.space = ssam_pkg::SP_ANALOG_INPUTS;
                    r.index = ofs;
                end else if (in_range(ofs, `SSAM_OFS_3000, `SSAM_N_32)) begin
                    r.space = ssam_pkg::SP_GLOBAL_ANALOG_INPUTS;
                    r.index = ofs - `SSAM_OFS_3000;
                end else if (in_range(ofs, `SSAM_OFS_4000, `SSAM_N_200)) begin
                    r.space = ssam_pkg::SP_SYSTEM_REGISTERS;
                    r.index = ofs - `SSAM_OFS_4000;
                end
            end
            `SSAM_FC_RD_HOLD, `SSAM_FC_WR_REG, `SSAM_FC_WR_REGS: begin
                // General registers run on from 512 through the 3000 window without a break
                if (in_range(ofs, `SSAM_OFS_0, `SSAM_N_256)) begin
                    r.space = ssam_pkg::SP_ANALOG_OUTPUTS;
                    r.index = ofs;
                end else if (in_range(ofs, `SSAM_OFS_512, `SSAM_N_2488)) begin
                    r.space = ssam_pkg::SP_GENERAL_REGISTERS;
                    r.index = ofs - `SSAM_OFS_512;
                end else if (in_range(ofs, `SSAM_OFS_3000, `SSAM_N_2048)) begin
                    r.space = ssam_pkg::SP_GENERAL_REGISTERS;
                    r.index = ofs - `SSAM_OFS_512;
                end else if (in_range(ofs, `SSAM_OFS_6000, `SSAM_N_32)) begin
                    r.space = ssam_pkg::SP_GLOBAL_ANALOG_OUTPUTS;
                    r.index = ofs - `SSAM_OFS_6000;
                end else if (in_range(ofs, `SSAM_OFS_10000, `SSAM_N_5000)) begin
                    r.space = ssam_pkg::SP_GENERAL_REGISTERS;
                    r.index = ofs - `SSAM_OFS_10000;
                end
            end
            default: r.err = ssam_pkg::EX_FUNCTION;
        endcase
        // Unmapped offset in a known function is an address error
        if (r.err == ssam_pkg::EX_NONE && r.space == ssam_pkg::SP_NONE) begin
            r.err = ssam_pkg::EX_ADDRESS;
        end
        map_space = r;
    endfunction

    // Reference path: digit splitter, one cycle behind
    ssam_ref_split u_split (
        .clk(clk),
        .resetn(resetn),
        .ref_valid(ref_valid),
        .ref_num(ref_num),
        .split_valid(split_valid),
        .split_digit(split_digit),
        .split_offset(split_offset),
        .split_bad(split_bad)
    );

    // Side data of the reference request travels alongside the split
    always_comb begin
        next_ref_id_q = ref_slave_id;
        next_ref_write_q = ref_write;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ref_id_q <= 8'h00;
            ref_write_q <= 1'b0;
        end else begin
            ref_id_q <= next_ref_id_q;
            ref_write_q <= next_ref_write_q;
        end
    end

    // Explicit requests to this slave win when both paths present in the same cycle
    always_comb begin
        dec = map_space(8'h00, 16'h0000);
        next_resp_valid = 1'b0;
        if (req_valid && req.slave_id == own_id) begin
            dec = map_space(req.func, req.offset);
            if (dec.err == ssam_pkg::EX_NONE && req.qty != 16'h0000 &&
                ({1'b0, dec.index} + {1'b0, req.qty} > {1'b0, `SSAM_MAX_QTY} +
                 {1'b0, dec.index} || req.qty > `SSAM_MAX_QTY)) begin
                dec.err = ssam_pkg::EX_ADDRESS;
            end
            next_resp_valid = 1'b1;
        end else if (split_valid && ref_id_q == own_id) begin
            unique case (split_digit)
                4'h0: dec = map_space(ref_write_q ? `SSAM_FC_WR_COIL : `SSAM_FC_RD_COILS,
                                      split_offset);
                4'h1: dec = map_space(`SSAM_FC_RD_INPUTS, split_offset);
                4'h3: dec = map_space(`SSAM_FC_RD_INREG, split_offset);
                4'h4: dec = map_space(ref_write_q ? `SSAM_FC_WR_REG : `SSAM_FC_RD_HOLD,
                                      split_offset);
                default: dec = map_space(8'h00, 16'h0000);
            endcase
            if (split_bad) begin
                dec.space = ssam_pkg::SP_NONE;
                dec.err = ssam_pkg::EX_ADDRESS;
            end
            next_resp_valid = 1'b1;
        end
        next_resp = dec;
    end

    // Answer register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            resp_valid <= 1'b0;
            resp <= '0;
        end else begin
            resp_valid <= next_resp_valid;
            resp <= next_resp;
        end
    end

    // Checks
    a_other_slave_silent: assert property (@(posedge clk) disable iff (!resetn)
        (req_valid && req.slave_id != own_id && !(split_valid && ref_id_q == own_id))
        |=> !resp_valid) else $error("answer to foreign slave");
    a_input_bits_map: assert property (@(posedge clk) disable iff (!resetn)
        (req_valid && req.slave_id == own_id && req.func == `SSAM_FC_RD_INPUTS &&
         req.offset == `SSAM_OFS_4000) |=> (resp.space == ssam_pkg::SP_SYSTEM_BITS &&
         resp.index == 16'h0000)) else $error("system bit base wrong");
    a_coil_map: assert property (@(posedge clk) disable iff (!resetn)
        (req_valid && req.slave_id == own_id && req.func == `SSAM_FC_RD_COILS &&
         req.offset == `SSAM_OFS_9000 + 16'h00ff) |=>
        (resp.space == ssam_pkg::SP_GLOBAL_OUTPUT_BITS && resp.index == 16'h00ff))
        else $error("global output top wrong");
    a_coil_write: assert property (@(posedge clk) disable iff (!resetn)
        (req_valid && req.slave_id == own_id && req.func == `SSAM_FC_WR_COILS &&
         req.offset == `SSAM_OFS_6000) |=> (resp.write && resp.space ==
         ssam_pkg::SP_TEMP_BITS)) else $error("coil write map wrong");
    a_inreg_map: assert property (@(posedge clk) disable iff (!resetn)
        (req_valid && req.slave_id == own_id && req.func == `SSAM_FC_RD_INREG &&
         req.offset == `SSAM_OFS_3000 + `SSAM_N_32) |=> resp.err == ssam_pkg::EX_ADDRESS)
        else $error("global analog input limit wrong");
    a_hold_map: assert property (@(posedge clk) disable iff (!resetn)
        (req_valid && req.slave_id == own_id && req.func == `SSAM_FC_RD_HOLD &&
         req.offset == `SSAM_OFS_10000) |=> (resp.space ==
         ssam_pkg::SP_GENERAL_REGISTERS && resp.index == 16'h0000))
        else $error("general register base wrong");
    a_bad_func: assert property (@(posedge clk) disable iff (!resetn)
        (req_valid && req.slave_id == own_id && req.func == 8'h07) |=>
        (resp_valid && resp.err == ssam_pkg::EX_FUNCTION)) else $error("bad func accepted");
    a_ref_one_based: assert property (@(posedge clk) disable iff (!resetn)
        (ref_valid && ref_slave_id == own_id && ref_num == 17'h0271a && !req_valid)
        ##1 !req_valid |=> (resp_valid && resp.space == ssam_pkg::SP_INPUT_BITS &&
        resp.index == 16'h0009)) else $error("reference index wrong");
    c_ref_path: cover property (@(posedge clk) disable iff (!resetn)
        split_valid && ref_id_q == own_id && !req_valid);
    c_write: cover property (@(posedge clk) disable iff (!resetn) resp_valid && resp.write);
    c_addr_err: cover property (@(posedge clk) disable iff (!resetn)
        resp_valid && resp.err == ssam_pkg::EX_ADDRESS);
endmodule

/* File: verification/ssam_master_model.sv */
// Serial master stand-in that presents explicit and reference requests to the decoder.
// Assumes the bench calls its tasks just after a rising clock edge, once per edge.
`timescale 1ns/1ps
module ssam_master_model (
    // Explicit request
    output logic req_valid,
    output ssam_pkg::ssam_req_t req,
    // Reference request
    output logic ref_valid,
    output logic [7:0] ref_slave_id,
    output logic ref_write,
    output logic [16:0] ref_num
);
    // Quiet bus at time zero
    initial begin
        req_valid = 1'b0;
        req = '0;
        ref_valid = 1'b0;
        ref_slave_id = 8'h00;
        ref_write = 1'b0;
        ref_num = 17'h00000;
    end

    // Fields are scrambled when idle, so a decoder that reads stale values is caught
    task automatic drive_req(input logic v, input ssam_pkg::ssam_req_t r);
        req_valid <= v;
        req <= v ? r : ~req;
    endtask

    // A reference names its slave and carries type digit plus one-based index
    task automatic drive_ref(input logic v, input logic [7:0] id, input logic w,
            input logic [16:0] n);
        ref_valid <= v;
        ref_slave_id <= v ? id : ~ref_slave_id;
        ref_write <= v ? w : ~ref_write;
        ref_num <= v ? n : ~ref_num;
    endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the address map decoder with a model of the serial master.
// Assumes the decoder answers one cycle after explicit and two after reference requests.
`timescale 1ns/1ps
module testbench;
    typedef struct {int cls; int start; int n; ssam_pkg::ssam_space_t sp;} ssam_rng_t;
    logic clk;
    logic resetn;
    logic [7:0] own_id;
    logic req_valid;
    ssam_pkg::ssam_req_t req;
    logic ref_valid;
    logic [7:0] ref_slave_id;
    logic ref_write;
    logic [16:0] ref_num;
    logic resp_valid;
    ssam_pkg::ssam_resp_t resp;
    int miscompares;
    int n_tests;
    int cycles;
    integer seed;
    ssam_pkg::ssam_req_t q[$];
    logic [7:0] fc [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10, 8'h07};
    logic [7:0] fcls [4] = '{8'h01, 8'h02, 8'h04, 8'h03};
    // Class 0 coils, 1 inputs, 2 input registers, 3 holding registers
    ssam_rng_t map [15] = '{'{0, 0, 1024, ssam_pkg::SP_OUTPUT_BITS},
        '{0, 3000, 1024, ssam_pkg::SP_MEMORY_BITS}, '{0, 6000, 1024, ssam_pkg::SP_TEMP_BITS},
        '{0, 9000, 256, ssam_pkg::SP_GLOBAL_OUTPUT_BITS}, '{1, 0, 1024, ssam_pkg::SP_INPUT_BITS},
        '{1, 3000, 256, ssam_pkg::SP_GLOBAL_INPUT_BITS}, '{1, 4000, 256, ssam_pkg::SP_SYSTEM_BITS},
        '{1, 5000, 10, ssam_pkg::SP_KEY_BITS}, '{2, 0, 256, ssam_pkg::SP_ANALOG_INPUTS},
        '{2, 3000, 32, ssam_pkg::SP_GLOBAL_ANALOG_INPUTS},
        '{2, 4000, 200, ssam_pkg::SP_SYSTEM_REGISTERS}, '{3, 0, 256, ssam_pkg::SP_ANALOG_OUTPUTS},
        '{3, 512, 4536, ssam_pkg::SP_GENERAL_REGISTERS},
        '{3, 6000, 32, ssam_pkg::SP_GLOBAL_ANALOG_OUTPUTS},
        '{3, 10000, 5000, ssam_pkg::SP_GENERAL_REGISTERS}};

    ssam_master_model u_master (.req_valid(req_valid), .req(req), .ref_valid(ref_valid),
        .ref_slave_id(ref_slave_id), .ref_write(ref_write), .ref_num(ref_num));
    ssam_decoder DUT (.clk(clk), .resetn(resetn), .own_id(own_id), .req_valid(req_valid),
        .req(req), .ref_valid(ref_valid), .ref_slave_id(ref_slave_id), .ref_write(ref_write),
        .ref_num(ref_num), .resp_valid(resp_valid), .resp(resp));

    // 10 MHz clock
    always #50 clk = ~clk;

    // Expected answer; a gap between spaces is an address fault with no space,
    // a quantity above 2000 keeps the space but is an address fault too
    function automatic ssam_pkg::ssam_resp_t exp_decode(input logic [7:0] f, input int o,
            input int n);
        ssam_pkg::ssam_resp_t e;
        int c;
        e = '0;
        c = (f == 1 || f == 5 || f == 15) ? 0 : f == 2 ? 1 : f == 4 ? 2 :
            (f == 3 || f == 6 || f == 16) ? 3 : -1;
        e.write = (f == 5 || f == 15 || f == 6 || f == 16);
        e.err = (c < 0) ? ssam_pkg::EX_FUNCTION : ssam_pkg::EX_ADDRESS;
        for (int i = 0; i < 15; i++) begin
            if (map[i].cls == c && o >= map[i].start && o < map[i].start + map[i].n) begin
                e.space = map[i].sp;
                e.index = 16'(o - map[i].start);
                e.err = ssam_pkg::EX_NONE;
            end
        end
        if (e.err == ssam_pkg::EX_NONE && n > 2000) begin
            e.err = ssam_pkg::EX_ADDRESS;
        end
        return e;
    endfunction

    // Reference: leading digit picks the type, the rest is a one-based index
    function automatic ssam_pkg::ssam_resp_t ref_exp(input int n, input logic w);
        logic [7:0] f;
        ssam_pkg::ssam_resp_t e;
        f = n / 10000 == 0 ? (w ? 8'h05 : 8'h01) : n / 10000 == 1 ? 8'h02 :
            n / 10000 == 3 ? 8'h04 : n / 10000 == 4 ? (w ? 8'h06 : 8'h03) : 8'h00;
        e = exp_decode(f, n % 10000 - 1, 1);
        // Index zero or a number past the last type is an address fault, whatever the digit
        if (n % 10000 == 0 || n >= 50000) begin
            e.space = ssam_pkg::SP_NONE;
            e.err = ssam_pkg::EX_ADDRESS;
        end
        return e;
    endfunction

    // Mostly own slave, offsets across each space and up to two past either edge, a few oversized quantities
    function automatic ssam_pkg::ssam_req_t rand_req();
        ssam_pkg::ssam_req_t r;
        int i;
        i = $unsigned($random(seed)) % 15;
        r.slave_id = ($random(seed) & 3) == 0 ? 8'h22 : 8'h11;
        r.func = fc[$unsigned($random(seed)) % 9];
        r.offset = 16'(map[i].start + $unsigned($random(seed)) % (map[i].n + 4) - 2);
        r.qty = ($random(seed) & 31) == 0 ? 16'h07d1 : 16'(1 + $unsigned($random(seed)) % 2000);
        return r;
    endfunction

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Index and direction carry meaning only on a clean answer
    task automatic check_resp(input logic v, input ssam_pkg::ssam_resp_t e);
        check("resp_valid", 24'(resp_valid), 24'(v));
        if (v) begin
            check("space", 24'(resp.space), 24'(e.space));
            check("err", 24'(resp.err), 24'(e.err));
            if (e.err == ssam_pkg::EX_NONE) begin
                check("index", 24'(resp.index), 24'(e.index));
                check("write", 24'(resp.write), 24'(e.write));
            end
        end
    endtask

    // Back to back: each negedge sees the answer to the previous cycle's request
    task automatic run_exp();
        ssam_pkg::ssam_req_t r;
        ssam_pkg::ssam_req_t p;
        ssam_pkg::ssam_resp_t e;
        for (int i = 0; i <= q.size(); i++) begin
            r = (i < q.size()) ? q[i] : '0;
            @(posedge clk);
            u_master.drive_req(i < q.size(), r);
            @(negedge clk);
            if (i > 0) begin
                e = exp_decode(p.func, p.offset, p.qty);
                check_resp(p.slave_id == own_id, e);
            end
            p = r;
        end
    endtask

    task automatic do_ref(input int n, input logic w, input logic [7:0] id);
        @(posedge clk);
        u_master.drive_ref(1'b1, id, w, 17'(n));
        @(posedge clk);
        u_master.drive_ref(1'b0, id, w, 17'(n));
        @(negedge clk);
        check_resp(1'b0, '0);
        @(negedge clk);
        check_resp(id == own_id, ref_exp(n, w));
        @(negedge clk);
        check_resp(1'b0, '0);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard, well above the fewer than one thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end

    // Main sequence
    initial begin
        int refs [20] = '{10010, 10001, 13001, 14256, 15010, 15011, 1, 3001, 6001, 9257,
            30001, 33032, 34200, 40001, 40513, 43001, 46033, 20001, 10000, 20000};
        seed = 73;
        clk = 1'b0;
        resetn = 1'b0;
        own_id = 8'h11;
        miscompares = 0;
        n_tests = 0;
        cycles = 0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        check("reset", 24'({resp_valid, resp}), 24'h0);
        @(posedge clk);
        resetn <= 1'b1;
        // Every code at offset 0, every space at its last entry, a quantity just too big
        for (int i = 0; i < 9; i++) q.push_back('{8'h11, fc[i], 16'h0000, 16'h0001});
        for (int i = 0; i < 15; i++)
            q.push_back('{8'h11, fcls[map[i].cls], 16'(map[i].start + map[i].n - 1), 16'h07d0});
        q.push_back('{8'h11, 8'h03, 16'h0bb8, 16'h07d1});
        // Corners the assertions watch: temp coil write, one past global analog inputs, far registers
        q.push_back('{8'h11, 8'h0f, 16'h1770, 16'h0001});
        q.push_back('{8'h11, 8'h04, 16'h0bd8, 16'h0001});
        q.push_back('{8'h11, 8'h03, 16'h2710, 16'h0001});
        for (int i = 0; i < 400; i++) q.push_back(rand_req());
        run_exp();
        foreach (refs[i]) do_ref(refs[i], 1'b0, 8'h11);
        foreach (refs[i]) do_ref(refs[i], 1'b1, 8'h11);
        for (int i = 0; i < 40; i++)
            do_ref(($unsigned($random(seed)) % 5) * 10000 + $unsigned($random(seed)) % 10000,
                1'(($random(seed))), (i % 5 == 0) ? 8'h22 : 8'h11);
        // An explicit answer landing with a reference answer wins; the reference is lost
        @(posedge clk);
        u_master.drive_ref(1'b1, 8'h11, 1'b0, 17'd10010);
        @(posedge clk);
        u_master.drive_ref(1'b0, 8'h11, 1'b0, 17'd10010);
        u_master.drive_req(1'b1, '{8'h11, 8'h02, 16'h0fa0, 16'h0001});
        @(posedge clk);
        u_master.drive_req(1'b0, '0);
        @(negedge clk);
        check_resp(1'b1, exp_decode(8'h02, 4000, 1));
        @(negedge clk);
        check_resp(1'b0, '0);
        // Reset in mid-run drops a pending request and clears the answer
        @(posedge clk);
        u_master.drive_req(1'b1, '{8'h11, 8'h02, 16'h0fa0, 16'h0001});
        resetn <= 1'b0;
        @(posedge clk);
        u_master.drive_req(1'b0, '0);
        @(negedge clk);
        check("reset", 24'({resp_valid, resp}), 24'h0);
        @(posedge clk);
        resetn <= 1'b1;
        // First request after release is answered normally
        @(posedge clk);
        u_master.drive_req(1'b1, '{8'h11, 8'h01, 16'h2328, 16'h0001});
        @(posedge clk);
        u_master.drive_req(1'b0, '0);
        @(negedge clk);
        check_resp(1'b1, exp_decode(8'h01, 9000, 1));
        final_report();
    end
endmodule
